// File: src/ber_checker_map.vh
// Register map, field positions and reset values of the lane bit-error checker
`ifndef BER_CHECKER_MAP_VH
`define BER_CHECKER_MAP_VH

`define ADDR_W 10
`define ADDR_TEST_CONTROL 10'h316
`define ADDR_BER_THRESHOLD_LOW 10'h317
`define ADDR_BER_THRESHOLD_MID 10'h318
`define ADDR_BER_THRESHOLD_HIGH 10'h319
`define ADDR_BER_ERROR_COUNT_LOW 10'h31a
`define ADDR_BER_ERROR_COUNT_MID 10'h31b
`define ADDR_BER_ERROR_COUNT_HIGH 10'h31c
`define ADDR_LANE_PASS_FLAGS 10'h31d
`define ADDR_CAPTURE_CONTROL 10'h31e
`define ADDR_CAPTURE_BYTE_0 10'h31f
`define ADDR_CAPTURE_BYTE_1 10'h320
`define ADDR_CAPTURE_BYTE_2 10'h321
`define ADDR_CAPTURE_BYTE_3 10'h322
`define ADDR_CAPTURE_BYTE_4 10'h323

// Test control fields
`define TC_CLEAR_BIT 0
`define TC_RUN_BIT 1
`define TC_SEQ_LSB 2
`define TC_SEQ_MSB 3
`define TC_TALLY_LSB 4
`define TC_TALLY_MSB 6

// Capture control fields
`define CC_CMD_BIT 0
`define CC_MODE_BIT 1
`define CC_LANE_LSB 2
`define CC_LANE_MSB 4

// Sequence codes
`define SEQ_PRBS7 2'h0
`define SEQ_PRBS15 2'h1
`define SEQ_PRBS31 2'h2
`define SEQ_UNUSED 2'h3

// Reset values and the error count ceiling
`define RST_BYTE 8'h00
`define RST_THRESHOLD 24'h000000
`define RST_COUNT 24'h000000
`define RST_HIST 31'h00000000
`define COUNT_MAX 24'hffffff
`define RST_PASS 8'hff
`define RST_TEST_CONTROL 7'h00
`define RST_LANE_SEL 3'h0

`endif

// File: src/prbs_lane_check.v
// Self-synchronising pattern checker and saturating error tally for one lane
`timescale 1ns/100ps
module prbs_lane_check #(
    parameter W = 40
) (
    input wire clk_sys,
    input wire arst_n,
    input wire clear,
    input wire run,
    input wire [1:0] sequence_select,
    input wire [23:0] threshold,
    input wire [W-1:0] lane_word,
    output reg err_pulse,
    output reg [23:0] err_count,
    output reg pass
);
`include "ber_checker_map.vh"

    reg [30:0] hist;
    reg primed;
    reg [30:0] next_hist;
    reg [23:0] next_count;
    reg [24:0] sum;
    reg [7:0] errs;
    reg predicted;
    integer i;

    // Bit 0 of the word is the earliest bit; hist[k-1] holds the bit k places back
    always @* begin
        next_hist = hist;
        errs = 8'h00;
        predicted = 1'b0;
        for (i = 0; i < W; i = i + 1) begin
            case (sequence_select)
                `SEQ_PRBS7: predicted = next_hist[6] ^ next_hist[5];
                `SEQ_PRBS15: predicted = next_hist[14] ^ next_hist[13];
                `SEQ_PRBS31: predicted = next_hist[30] ^ next_hist[27];
                default: predicted = lane_word[i]; // Unused code never flags
            endcase
            if (predicted != lane_word[i]) begin
                errs = errs + 8'h01;
            end
            next_hist = {next_hist[29:0], lane_word[i]};
        end
        sum = {1'b0, err_count} + {17'h00000, errs};
        if (!primed) begin
            next_count = err_count; // History not yet filled, so no verdict
        end else if (sum[24]) begin
            next_count = `COUNT_MAX; // Saturate rather than wrap to a false pass
        end else begin
            next_count = sum[23:0];
        end
    end

    // Checking state; clear wins over run
    always @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            hist <= `RST_HIST;
            primed <= 1'b0;
            err_count <= `RST_COUNT;
            pass <= 1'b1;
            err_pulse <= 1'b0;
        end else if (clear) begin
            hist <= `RST_HIST;
            primed <= 1'b0;
            err_count <= `RST_COUNT;
            pass <= 1'b1;
            err_pulse <= 1'b0;
        end else if (run) begin
            hist <= next_hist;
            primed <= 1'b1;
            err_count <= next_count;
            err_pulse <= primed && (errs != 8'h00);
            if (next_count > threshold) begin
                pass <= 1'b0;
            end
        end else begin
            primed <= 1'b0; // Re-prime after a stop so stale history never counts
            err_pulse <= 1'b0;
        end
    end

endmodule // prbs_lane_check

// File: src/lane_snapshot.v
// Forty-bit snapshot of one chosen lane, taken on command or on a bit error
`timescale 1ns/100ps
module lane_snapshot #(
    parameter W = 40,
    parameter LANES = 8,
    parameter SEL_W = 3
) (
    input wire clk_sys,
    input wire arst_n,
    input wire [LANES*W-1:0] lane_words,
    input wire [LANES-1:0] lane_errs,
    input wire [SEL_W-1:0] capture_lane_select,
    input wire capture_on_error,
    input wire command_edge,
    output reg [W-1:0] captured_lane_bits
);

    wire [W-1:0] chosen;
    wire trigger;

    assign chosen = lane_words[capture_lane_select*W +: W];
    // Error pulse lags its word by one cycle, so the error mode grabs the next word
    assign trigger = command_edge || (capture_on_error && lane_errs[capture_lane_select]);

    // Snapshot holds until the next trigger
    always @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            captured_lane_bits <= {W{1'b0}};
        end else if (trigger) begin
            captured_lane_bits <= chosen;
        end
    end

endmodule // lane_snapshot

// File: src/serdes_prbs_ber_checker.v
// Multi-lane pattern bit-error checker with register port and data snapshot
// Overview of operation
// - Writable 24-bit error threshold, three bytes, reset zero
// - Threshold decides when lane pass bit clears
// - Selected lane error count readable, three bytes
// - One pass bit per lane, reset all pass
// - Capture lane selector bits 4..2 choose lane
// - Mode bit 1 captures on bit error
// - Command bit rising edge stores 40-bit snapshot
// - Test control bits 6..4 select reported lane
// - Bits 3..2 pick PRBS7, PRBS15, PRBS31
// - Test control bit 1 starts and stops
// - Test control bit 0 clears checker and counters
`timescale 1ns/100ps
module serdes_prbs_ber_checker #(
    parameter LANES = 8,
    parameter W = 40
) (
    input wire clk_sys,
    input wire arst_n,
    input wire [9:0] reg_addr,
    input wire reg_wr_en,
    input wire [7:0] reg_wdata,
    output reg [7:0] reg_rdata,
    input wire [LANES*W-1:0] lane_words
);
`include "ber_checker_map.vh"

    // Software state
    reg [23:0] threshold;
    reg [6:0] test_control;
    reg [2:0] capture_lane_select;
    reg capture_on_error;
    reg capture_command;
    reg capture_command_d;

    wire checker_clear;
    wire checker_run;
    wire [1:0] sequence_select;
    wire [2:0] tally_lane_select;
    wire [LANES-1:0] lane_errs;
    wire [LANES-1:0] lane_pass_bits;
    wire [LANES*24-1:0] tallies;
    wire [23:0] tally;
    wire [W-1:0] captured_lane_bits;
    wire command_edge;
    reg [7:0] next_rdata;

    assign checker_clear = test_control[`TC_CLEAR_BIT];
    assign checker_run = test_control[`TC_RUN_BIT];
    assign sequence_select = test_control[`TC_SEQ_MSB:`TC_SEQ_LSB];
    assign tally_lane_select = test_control[`TC_TALLY_MSB:`TC_TALLY_LSB];
    assign tally = tallies[tally_lane_select*24 +: 24];
    assign command_edge = capture_command && !capture_command_d;

    // Register writes; read-only addresses and reserved bits ignore writes
    always @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            threshold <= `RST_THRESHOLD;
            test_control <= `RST_TEST_CONTROL;
            capture_lane_select <= `RST_LANE_SEL;
            capture_on_error <= 1'b0;
            capture_command <= 1'b0;
        end else if (reg_wr_en) begin
            if (reg_addr == `ADDR_TEST_CONTROL) begin
                test_control <= reg_wdata[6:0];
            end else if (reg_addr == `ADDR_BER_THRESHOLD_LOW) begin
                threshold[7:0] <= reg_wdata;
            end else if (reg_addr == `ADDR_BER_THRESHOLD_MID) begin
                threshold[15:8] <= reg_wdata;
            end else if (reg_addr == `ADDR_BER_THRESHOLD_HIGH) begin
                threshold[23:16] <= reg_wdata;
            end else if (reg_addr == `ADDR_CAPTURE_CONTROL) begin
                capture_lane_select <= reg_wdata[`CC_LANE_MSB:`CC_LANE_LSB];
                capture_on_error <= reg_wdata[`CC_MODE_BIT];
                capture_command <= reg_wdata[`CC_CMD_BIT];
            end
        end
    end

    // Edge history of the command bit; software must write 0 then 1 to grab again
    always @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            capture_command_d <= 1'b0;
        end else begin
            capture_command_d <= capture_command;
        end
    end

    // One checker per lane
    genvar g;
    generate
        for (g = 0; g < LANES; g = g + 1) begin : lane
            prbs_lane_check #(
                .W(W)
            ) u_check (
                .clk_sys(clk_sys),
                .arst_n(arst_n),
                .clear(checker_clear),
                .run(checker_run),
                .sequence_select(sequence_select),
                .threshold(threshold),
                .lane_word(lane_words[g*W +: W]),
                .err_pulse(lane_errs[g]),
                .err_count(tallies[g*24 +: 24]),
                .pass(lane_pass_bits[g])
            );
        end
    endgenerate

    lane_snapshot #(
        .W(W),
        .LANES(LANES),
        .SEL_W(3)
    ) u_snapshot (
        .clk_sys(clk_sys),
        .arst_n(arst_n),
        .lane_words(lane_words),
        .lane_errs(lane_errs),
        .capture_lane_select(capture_lane_select),
        .capture_on_error(capture_on_error),
        .command_edge(command_edge),
        .captured_lane_bits(captured_lane_bits)
    );

    // Read decode; unmapped addresses read zero
    always @* begin
        next_rdata = `RST_BYTE;
        if (reg_addr == `ADDR_TEST_CONTROL) begin
            next_rdata = {1'b0, test_control};
        end else if (reg_addr == `ADDR_BER_THRESHOLD_LOW) begin
            next_rdata = threshold[7:0];
        end else if (reg_addr == `ADDR_BER_THRESHOLD_MID) begin
            next_rdata = threshold[15:8];
        end else if (reg_addr == `ADDR_BER_THRESHOLD_HIGH) begin
            next_rdata = threshold[23:16];
        end else if (reg_addr == `ADDR_BER_ERROR_COUNT_LOW) begin
            next_rdata = tally[7:0];
        end else if (reg_addr == `ADDR_BER_ERROR_COUNT_MID) begin
            next_rdata = tally[15:8];
        end else if (reg_addr == `ADDR_BER_ERROR_COUNT_HIGH) begin
            next_rdata = tally[23:16];
        end else if (reg_addr == `ADDR_LANE_PASS_FLAGS) begin
            next_rdata = lane_pass_bits[7:0];
        end else if (reg_addr == `ADDR_CAPTURE_CONTROL) begin
            next_rdata = {3'h0, capture_lane_select, capture_on_error, capture_command};
        end else if (reg_addr == `ADDR_CAPTURE_BYTE_0) begin
            next_rdata = captured_lane_bits[7:0];
        end else if (reg_addr == `ADDR_CAPTURE_BYTE_1) begin
            next_rdata = captured_lane_bits[15:8];
        end else if (reg_addr == `ADDR_CAPTURE_BYTE_2) begin
            next_rdata = captured_lane_bits[23:16];
        end else if (reg_addr == `ADDR_CAPTURE_BYTE_3) begin
            next_rdata = captured_lane_bits[31:24];
        end else if (reg_addr == `ADDR_CAPTURE_BYTE_4) begin
            next_rdata = captured_lane_bits[39:32];
        end
    end

    // Registered read data: answer one cycle after the address
    always @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            reg_rdata <= `RST_BYTE;
        end else begin
            reg_rdata <= next_rdata;
        end
    end

endmodule // serdes_prbs_ber_checker

// File: verif/serdes_prbs_ber_checker_sva.sv
// Port assertions for the lane bit-error checker
`timescale 1ns/100ps
module serdes_prbs_ber_checker_sva (
    input wire clk_sys,
    input wire arst_n,
    input wire [9:0] reg_addr,
    input wire reg_wr_en,
    input wire [7:0] reg_wdata,
    input wire [7:0] reg_rdata
);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!arst_n);
    // Read data lags the address by one cycle, so each check looks one edge on
    thr_readback_a: assert property (
        reg_wr_en && reg_addr inside {[10'h317:10'h319]} ##1 !reg_wr_en && $stable(reg_addr)
        |=> reg_rdata == $past(reg_wdata, 2)) else $error("threshold readback");
    tctl_readback_a: assert property (
        reg_wr_en && reg_addr == 10'h316 ##1 !reg_wr_en && reg_addr == 10'h316
        |=> reg_rdata == ($past(reg_wdata, 2) & 8'h7f)) else $error("control readback");
    cctl_readback_a: assert property (
        reg_wr_en && reg_addr == 10'h31e ##1 !reg_wr_en && reg_addr == 10'h31e
        |=> reg_rdata == ($past(reg_wdata, 2) & 8'h1f)) else $error("capture readback");
    unmapped_zero_a: assert property (
        reg_addr < 10'h316 || reg_addr > 10'h323 |=> reg_rdata == 8'h00) else $error("unmapped");
    rsv_tctl_a: assert property (
        reg_addr == 10'h316 |=> !reg_rdata[7]) else $error("reserved bit");
    rsv_cctl_a: assert property (
        reg_addr == 10'h31e |=> reg_rdata[7:5] == 3'h0) else $error("reserved bits");
    // Clear held two cycles must leave the reported count at zero
    clr_count_a: assert property (
        reg_wr_en && reg_addr == 10'h316 && reg_wdata[0] ##1 !reg_wr_en
        ##1 !reg_wr_en && reg_addr == 10'h31a |=> reg_rdata == 8'h00) else $error("clear count");
    clr_pass_a: assert property (
        reg_wr_en && reg_addr == 10'h316 && reg_wdata[0] ##1 !reg_wr_en
        ##1 !reg_wr_en && reg_addr == 10'h31d |=> reg_rdata == 8'hff) else $error("clear pass");
    cover property (reg_wr_en && reg_addr == 10'h31e && reg_wdata[0]);
    cover property (reg_addr == 10'h31d ##1 reg_rdata != 8'hff);
    cover property (reg_wr_en && reg_addr == 10'h316 && reg_wdata[1]);
endmodule // serdes_prbs_ber_checker_sva
bind serdes_prbs_ber_checker serdes_prbs_ber_checker_sva u_sva (.clk_sys(clk_sys),
    .arst_n(arst_n), .reg_addr(reg_addr), .reg_wr_en(reg_wr_en), .reg_wdata(reg_wdata),
    .reg_rdata(reg_rdata));

// File: verif/prbs_lane_source.sv
// Lane transmitter model sending one test pattern on all eight lanes
`timescale 1ns/100ps
module prbs_lane_source (
    input wire clk_sys,
    input wire arst_n,
    input wire [1:0] seq,
    input wire hold,
    input wire flip,
    output logic [319:0] lane_words
);
    logic [30:0] h, t;
    logic [39:0] w;
    // Forty serial steps per clock, bit 0 sent first
    always_comb begin
        t = h;
        w = 40'h0;
        for (int i = 0; i < 40; i++) begin
            w[i] = seq == 2'h0 ? t[6] ^ t[5] : seq == 2'h1 ? t[14] ^ t[13] : t[30] ^ t[27];
            t = {t[29:0], w[i]};
        end
    end
    // Generator state and lane outputs advance once per clock
    always @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            h <= 31'h1;
            lane_words <= '0;
        end else begin
            h <= t;
            // Flip spoils one bit on lane 3; history keeps the true bit
            for (int n = 0; n < 8; n++)
                lane_words[n*40+:40] <= hold ? {5{n[2:0], 5'h0a}} : w ^ {19'h0, flip && n == 3, 20'h0};
        end
    end
endmodule // prbs_lane_source

// File: verif/serdes_prbs_ber_checker_tb.sv
// Self-checking testbench for the lane bit-error checker
`timescale 1ns/100ps
module serdes_prbs_ber_checker_tb;
    logic clk_sys, arst_n, reg_wr_en, hold, flip;
    logic [9:0] reg_addr;
    logic [7:0] reg_wdata, reg_rdata;
    logic [1:0] seq;
    logic [319:0] lane_words;
    int failures = 0;
    int cmp_count = 0;
    serdes_prbs_ber_checker u_dut (.clk_sys(clk_sys), .arst_n(arst_n), .reg_addr(reg_addr),
        .reg_wr_en(reg_wr_en), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
        .lane_words(lane_words));
    prbs_lane_source u_src (.clk_sys(clk_sys), .arst_n(arst_n), .seq(seq), .hold(hold),
        .flip(flip), .lane_words(lane_words));
    initial begin
        clk_sys = 1'b0;
        forever #2.5 clk_sys = ~clk_sys;
    end
    task cyc(input int n);
        repeat (n) @(posedge clk_sys);
    endtask
    task wr(input logic [9:0] a, input logic [7:0] d);
        @(posedge clk_sys);
        reg_addr <= a;
        reg_wr_en <= 1'b1;
        reg_wdata <= d;
        @(posedge clk_sys);
        reg_wr_en <= 1'b0;
    endtask
    // Read data answers the address one edge later
    task rd(input logic [9:0] a, output logic [7:0] d);
        @(posedge clk_sys);
        reg_addr <= a;
        @(posedge clk_sys);
        #1 d = reg_rdata;
    endtask
    task chk(input logic [9:0] a, input logic [7:0] e);
        logic [7:0] d;
        rd(a, d);
        cmp_count++;
        if (d !== e) begin
            failures++;
            $display("CHECK FAILED t=%0t addr %h got %h exp %h", $time, a, d, e);
        end
    endtask
    task print_verdict;
        $display("compares %0d mismatches %0d", cmp_count, failures);
        if (failures == 0 && cmp_count > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask
    task t_reset;
        for (int a = 'h317; a <= 'h323; a++) chk(a[9:0], a == 'h31d ? 8'hff : 8'h00);
        wr(10'h31d, 8'h00);
        chk(10'h31d, 8'hff);
        $display("end t_reset");
    endtask
    task t_regs;
        for (int i = 0; i < 3; i++) begin
            wr(10'(10'h317 + i), 8'(8'h11 * (i + 1)));
            chk(10'(10'h317 + i), 8'(8'h11 * (i + 1)));
        end
        wr(10'h316, 8'hff);
        chk(10'h316, 8'h7f);
        wr(10'h31e, 8'hfe);
        chk(10'h31e, 8'h1e);
        wr(10'h31e, 8'h00);
        wr(10'h316, 8'h01);
        chk(10'h31d, 8'hff);
        $display("end t_regs");
    endtask
    // One spoilt bit on lane 3 gives three errors; code 3 checks nothing
    task t_prbs;
        // Upper threshold bytes still hold the readback pattern; zero them first
        wr(10'h318, 8'h00);
        wr(10'h319, 8'h00);
        for (int c = 0; c < 4; c++) begin
            @(posedge clk_sys) seq <= c[1:0];
            wr(10'h317, c == 0 ? 8'h03 : 8'h02);
            wr(10'h316, 8'h31);
            chk(10'h31a, 8'h00);
            wr(10'h316, {4'h3, c[1:0], 2'b10});
            cyc(5);
            flip <= 1'b1;
            @(posedge clk_sys) flip <= 1'b0;
            cyc(5);
            wr(10'h316, {4'h3, c[1:0], 2'b00});
            chk(10'h31a, c == 3 ? 8'h00 : 8'h03);
            chk(10'h31d, c == 1 || c == 2 ? 8'hf7 : 8'hff);
        end
        $display("end t_prbs");
    endtask
    task t_capture;
        logic [39:0] exp_word;
        @(posedge clk_sys) hold <= 1'b1;
        wr(10'h31e, 8'h14);
        wr(10'h31e, 8'h15);
        for (int b = 0; b < 5; b++) chk(10'(10'h31f + b), 8'haa);
        @(posedge clk_sys) hold <= 1'b0;
        seq <= 2'h0;
        wr(10'h31e, 8'h15);
        chk(10'h31f, 8'haa);
        wr(10'h31e, 8'h0e);
        wr(10'h316, 8'h01);
        wr(10'h316, 8'h02);
        cyc(5);
        chk(10'h323, 8'haa);
        @(posedge clk_sys) flip <= 1'b1;
        @(posedge clk_sys) flip <= 1'b0;
        // Error pulse lags the spoilt word, so the word after it is the one kept
        @(posedge clk_sys);
        #1 exp_word = lane_words[159:120];
        cyc(2);
        for (int b = 0; b < 5; b++) chk(10'(10'h31f + b), exp_word[b*8+:8]);
        $display("end t_capture");
    endtask
    initial begin
        arst_n = 1'b0;
        reg_addr = '0;
        reg_wr_en = 1'b0;
        reg_wdata = '0;
        seq = 2'h0;
        hold = 1'b0;
        flip = 1'b0;
        cyc(4);
        arst_n <= 1'b1;
        t_reset;
        t_regs;
        t_prbs;
        t_capture;
        print_verdict;
    end
    // Tests need well under 2000 cycles; this cuts a hang short
    initial begin
        #50000;
        failures++;
        print_verdict;
    end
endmodule // serdes_prbs_ber_checker_tb
